// >>> hw/branch_bitset_skip_exec.sv
`timescale 1ns/10ps
// Functional notes
// - branch_if_negative jumps only when the negative flag is one.
// - branch_if_no_carry jumps only when carry is zero.
// - branch_if_not_negative jumps only when negative is zero.
// - branch_if_no_overflow jumps only when overflow is zero.
// - branch_if_not_zero jumps only when zero flag is zero.
// - conditional target is instruction address plus two plus twice signed low byte.
// - conditional branch: one cycle untaken, two taken; extra cycle does nothing.
// - branch phases: decode, read offset, process, pc write only if taken.
// - branch_always: sign-extended 11-bit offset, always jumps, two cycles.
// - set_register_bit forces the indexed bit of the register to one, one cycle.
// - bank bit zero selects access bank, else bank_select_reg picks the bank.
// - bank bit zero, extension on, address up to limit: indexed literal offset.
// - bit test discards fetched next word when bit matches: clear=0, set=1.
// - discarded word becomes a nop cycle; three cycles over a two-word one.
// - set_register_bit phases: decode, read, modify, write back.
// - pc change or true test costs a second cycle executed as nop.
// - a lone second word of a two-word instruction executes as nop.
module branch_bitset_skip_exec
    import exec_pkg::*;
#(
    parameter int PC_W = PC_W_DEFAULT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    output logic [PC_W-1:0] prog_addr,
    input wire logic [15:0] prog_rdata,
    output logic [DADDR_W-1:0] dm_addr,
    output logic dm_rd,
    output logic dm_wr,
    output logic [7:0] dm_wdata,
    input wire logic [7:0] dm_rdata,
    input wire logic [BANK_SEL_W-1:0] bank_select_reg,
    input wire logic ext_en,
    input wire logic [DADDR_W-1:0] index_base,
    input wire logic flag_negative,
    input wire logic flag_overflow,
    input wire logic flag_zero,
    input wire logic flag_carry,
    output logic [1:0] phase,
    output logic exec_nop,
    output logic branch_taken,
    output logic skip_next,
    output logic indexed_mode,
    output logic unsupported
);

    typedef struct packed {
        phase_e phase;
        logic [PC_W-1:0] pc;
        logic [15:0] ir;
        logic nop;
        logic taken;
        logic skip;
        logic [7:0] data;
        logic [DADDR_W-1:0] daddr;
        logic rd;
        logic wr;
        logic indexed;
        logic unsup;
    } state_s;

    state_s s_q;
    state_s s_d;

    // decode of the word under execution
    logic [7:0] opc_hi;
    logic [3:0] opc_nib;
    logic [4:0] opc_top5;
    logic [2:0] bit_idx;
    logic [7:0] bit_mask;
    logic active;
    logic is_br_neg;
    logic is_br_no_carry;
    logic is_br_not_neg;
    logic is_br_no_ovf;
    logic is_br_not_zero;
    logic is_cond_branch;
    logic is_branch_always;
    logic is_set_bit;
    logic is_skip_clear;
    logic is_skip_set;
    logic is_bit_op;
    logic is_plain_nop;
    logic is_second_word;
    logic known;
    logic cond_met;
    logic tested_bit;
    logic test_match;
    logic [PC_W-1:0] short_target;
    logic [PC_W-1:0] long_target;
    logic [DADDR_W-1:0] map_addr;
    logic map_indexed;

    assign opc_hi = s_q.ir[OPC_HI_LSB +: 8];
    assign opc_nib = s_q.ir[OPC_NIB_LSB +: 4];
    assign opc_top5 = s_q.ir[OPC_TOP5_LSB +: 5];
    assign bit_idx = s_q.ir[BIT_IDX_LSB +: 3];
    assign bit_mask = 8'h01 << bit_idx;

    // a flushed slot carries the nop word, but the flag also blocks decode
    assign active = !s_q.nop;

    assign is_br_neg = active && (opc_hi == OPC_BRANCH_IF_NEGATIVE);
    assign is_br_no_carry = active && (opc_hi == OPC_BRANCH_IF_NO_CARRY);
    assign is_br_not_neg = active && (opc_hi == OPC_BRANCH_IF_NOT_NEGATIVE);
    assign is_br_no_ovf = active && (opc_hi == OPC_BRANCH_IF_NO_OVERFLOW);
    assign is_br_not_zero = active && (opc_hi == OPC_BRANCH_IF_NOT_ZERO);
    assign is_cond_branch = is_br_neg || is_br_no_carry || is_br_not_neg || is_br_no_ovf || is_br_not_zero;
    assign is_branch_always = active && (opc_top5 == OPC_BRANCH_ALWAYS);
    assign is_set_bit = active && (opc_nib == OPC_SET_REGISTER_BIT);
    assign is_skip_clear = active && (opc_nib == OPC_TEST_BIT_SKIP_CLEAR);
    assign is_skip_set = active && (opc_nib == OPC_TEST_BIT_SKIP_SET);
    assign is_bit_op = is_set_bit || is_skip_clear || is_skip_set;
    assign is_plain_nop = s_q.ir == NOP_WORD;
    // operand word reached on its own: decodes to nothing and so idles
    assign is_second_word = opc_nib == OPC_SECOND_WORD;
    assign known = is_cond_branch || is_branch_always || is_bit_op || is_plain_nop || is_second_word;

    // flags are only looked at, never driven from here
    always_comb begin
        cond_met = 1'b0;
        if (is_br_neg) begin
            cond_met = flag_negative;
        end
        if (is_br_no_carry) begin
            cond_met = !flag_carry;
        end
        if (is_br_not_neg) begin
            cond_met = !flag_negative;
        end
        if (is_br_no_ovf) begin
            cond_met = !flag_overflow;
        end
        if (is_br_not_zero) begin
            cond_met = !flag_zero;
        end
    end

    assign tested_bit = dm_rdata[bit_idx];
    assign test_match = (is_skip_clear && !tested_bit) || (is_skip_set && tested_bit);

    // pc already points one word past the instruction, hence pc + 2n
    rel_target_add #(
        .PC_W(PC_W),
        .OFF_W(SHORT_OFF_W)
    ) u_short_target (
        .pc(s_q.pc),
        .offset(s_q.ir[SHORT_OFF_W-1:0]),
        .target(short_target)
    );

    rel_target_add #(
        .PC_W(PC_W),
        .OFF_W(LONG_OFF_W)
    ) u_long_target (
        .pc(s_q.pc),
        .offset(s_q.ir[LONG_OFF_W-1:0]),
        .target(long_target)
    );

    data_bank_map u_bank_map (
        .reg_sel(s_q.ir[7:0]),
        .bank_bit(s_q.ir[BANK_BIT_POS]),
        .bank_select_reg(bank_select_reg),
        .ext_en(ext_en),
        .index_base(index_base),
        .addr(map_addr),
        .indexed(map_indexed)
    );

    always_comb begin
        s_d = s_q;
        s_d.rd = 1'b0;
        s_d.wr = 1'b0;
        unique case (s_q.phase)
            PH_Q1: begin
                // decode; the read strobe lands in Q2 so data is back in Q3
                s_d.phase = PH_Q2;
                s_d.taken = 1'b0;
                s_d.skip = 1'b0;
                s_d.unsup = active && !known;
                s_d.indexed = 1'b0;
                if (is_bit_op) begin
                    s_d.daddr = map_addr;
                    s_d.indexed = map_indexed;
                    s_d.rd = 1'b1;
                end
            end
            PH_Q2: begin
                // offset sits in the held word; nothing to latch
                s_d.phase = PH_Q3;
            end
            PH_Q3: begin
                s_d.phase = PH_Q4;
                if (is_cond_branch) begin
                    s_d.taken = cond_met;
                end
                if (is_branch_always) begin
                    s_d.taken = 1'b1;
                end
                if (is_skip_clear || is_skip_set) begin
                    s_d.skip = test_match;
                end
                if (is_set_bit) begin
                    s_d.data = dm_rdata | bit_mask;
                    s_d.wr = 1'b1;
                end
            end
            PH_Q4: begin
                s_d.phase = PH_Q1;
                // taken and skip stand in Q4 only, so the flush slot starts clean
                s_d.taken = 1'b0;
                s_d.skip = 1'b0;
                if (s_q.taken) begin
                    s_d.pc = is_branch_always ? long_target : short_target;
                    // fetched word belongs to the old path: slot becomes a nop
                    s_d.ir = NOP_WORD;
                    s_d.nop = 1'b1;
                end else begin
                    s_d.pc = s_q.pc + PC_W'(PC_STEP);
                    if (s_q.skip) begin
                        s_d.ir = NOP_WORD;
                        s_d.nop = 1'b1;
                    end else begin
                        s_d.ir = prog_rdata;
                        s_d.nop = 1'b0;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q.phase <= PH_Q1;
            s_q.pc <= PC_W'(PC_RESET);
            s_q.ir <= NOP_WORD;
            s_q.nop <= 1'b1;
            s_q.taken <= 1'b0;
            s_q.skip <= 1'b0;
            s_q.data <= 8'h00;
            s_q.daddr <= '0;
            s_q.rd <= 1'b0;
            s_q.wr <= 1'b0;
            s_q.indexed <= 1'b0;
            s_q.unsup <= 1'b0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign prog_addr = s_q.pc;
    assign dm_addr = s_q.daddr;
    assign dm_rd = s_q.rd;
    assign dm_wr = s_q.wr;
    assign dm_wdata = s_q.data;
    assign phase = s_q.phase;
    assign exec_nop = s_q.nop;
    assign branch_taken = s_q.taken;
    assign skip_next = s_q.skip;
    assign indexed_mode = s_q.indexed;
    assign unsupported = s_q.unsup;

endmodule // branch_bitset_skip_exec

// >>> hw/data_bank_map.sv
`timescale 1ns/10ps
module data_bank_map
    import exec_pkg::*;
(
    input wire logic [7:0] reg_sel,
    input wire logic bank_bit,
    input wire logic [BANK_SEL_W-1:0] bank_select_reg,
    input wire logic ext_en,
    input wire logic [DADDR_W-1:0] index_base,
    output logic [DADDR_W-1:0] addr,
    output logic indexed
);

    logic low_half;
    logic [DADDR_W-1:0] sum;

    assign low_half = reg_sel <= INDEXED_LIMIT;
    assign indexed = !bank_bit && ext_en && low_half;
    assign sum = index_base + {{(DADDR_W-8){1'b0}}, reg_sel};

    always_comb begin
        if (indexed) begin
            addr = sum;
        end else if (bank_bit) begin
            addr = {bank_select_reg, reg_sel};
        end else if (low_half) begin
            addr = {{(DADDR_W-8){1'b0}}, reg_sel};
        end else begin
            addr = {ACCESS_HIGH_BANK, reg_sel};
        end
    end

endmodule // data_bank_map

// >>> hw/rel_target_add.sv
`timescale 1ns/10ps
module rel_target_add
    import exec_pkg::*;
#(
    parameter int PC_W = PC_W_DEFAULT,
    parameter int OFF_W = SHORT_OFF_W
) (
    input wire logic [PC_W-1:0] pc,
    input wire logic [OFF_W-1:0] offset,
    output logic [PC_W-1:0] target
);

    logic [PC_W-1:0] step;
    logic [PC_W-1:0] sum;

    // offset counts words, so it is doubled before the add
    assign step = {{(PC_W-OFF_W-1){offset[OFF_W-1]}}, offset, 1'b0};
    // carry out dropped on purpose: target wraps in the pc width
    assign sum = pc + step;
    assign target = {sum[PC_W-1:1], 1'b0};

endmodule // rel_target_add

// >>> include/exec_pkg.sv
package exec_pkg;

    // four phases of one instruction cycle, gray order
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } phase_e;

    // upper opcode byte of the conditional relative branches
    localparam logic [7:0] OPC_BRANCH_IF_NOT_ZERO = 8'he1;
    localparam logic [7:0] OPC_BRANCH_IF_NO_CARRY = 8'he3;
    localparam logic [7:0] OPC_BRANCH_IF_NO_OVERFLOW = 8'he5;
    localparam logic [7:0] OPC_BRANCH_IF_NEGATIVE = 8'he6;
    localparam logic [7:0] OPC_BRANCH_IF_NOT_NEGATIVE = 8'he7;

    // top five bits of the unconditional branch
    localparam logic [4:0] OPC_BRANCH_ALWAYS = 5'h1a;

    // top nibble of the bit-oriented instructions and of a lone second word
    localparam logic [3:0] OPC_SET_REGISTER_BIT = 4'h8;
    localparam logic [3:0] OPC_TEST_BIT_SKIP_SET = 4'ha;
    localparam logic [3:0] OPC_TEST_BIT_SKIP_CLEAR = 4'hb;
    localparam logic [3:0] OPC_SECOND_WORD = 4'hf;

    localparam logic [15:0] NOP_WORD = 16'h0000;

    // instruction word fields
    localparam int OPC_HI_LSB = 8;
    localparam int OPC_NIB_LSB = 12;
    localparam int OPC_TOP5_LSB = 11;
    localparam int BIT_IDX_LSB = 9;
    localparam int BANK_BIT_POS = 8;
    localparam int SHORT_OFF_W = 8;
    localparam int LONG_OFF_W = 11;

    // data memory addressing
    localparam int DADDR_W = 12;
    localparam int BANK_SEL_W = 4;
    localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;

    // program counter
    localparam int PC_W_DEFAULT = 21;
    localparam int PC_STEP = 2;
    localparam logic [PC_W_DEFAULT-1:0] PC_RESET = 21'h000000;

endpackage

// >>> tb/branch_bitset_skip_exec_bench.sv
`timescale 1ns/10ps
module branch_bitset_skip_exec_bench;
    import exec_pkg::*;
    logic clk, arst_n, clk_en, ext_en, fn, fo, fz, fc;
    logic dm_rd, dm_wr, exec_nop, branch_taken, skip_next, indexed_mode, unsupported;
    logic [PC_W_DEFAULT-1:0] prog_addr;
    logic [15:0] prog_rdata;
    logic [DADDR_W-1:0] dm_addr, index_base;
    logic [7:0] dm_wdata, dm_rdata;
    logic [BANK_SEL_W-1:0] bank_select_reg;
    logic [1:0] phase;
    int n_fail = 0;
    int n_checks = 0;

    branch_bitset_skip_exec uut (
        .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .prog_addr(prog_addr), .prog_rdata(prog_rdata),
        .dm_addr(dm_addr), .dm_rd(dm_rd), .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata),
        .bank_select_reg(bank_select_reg), .ext_en(ext_en), .index_base(index_base), .flag_negative(fn),
        .flag_overflow(fo), .flag_zero(fz), .flag_carry(fc), .phase(phase), .exec_nop(exec_nop),
        .branch_taken(branch_taken), .skip_next(skip_next), .indexed_mode(indexed_mode), .unsupported(unsupported)
    );
    prog_data_model m (
        .clk(clk), .prog_addr(prog_addr), .prog_rdata(prog_rdata), .dm_addr(dm_addr), .dm_rd(dm_rd),
        .dm_wr(dm_wr), .dm_wdata(dm_wdata), .dm_rdata(dm_rdata)
    );

    task automatic wrap_up();
        if (n_fail == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic step(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // reset restarts the fetch at address zero, so each case runs from a clean pc
    task automatic boot(logic [15:0] w0, logic [15:0] w1, logic [15:0] w2);
        m.pmem[0] = w0;
        m.pmem[1] = w1;
        m.pmem[2] = w2;
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
    endtask

    task automatic run_br(logic [15:0] w, logic tk, logic [PC_W_DEFAULT-1:0] exp);
        boot(w, NOP_WORD, NOP_WORD);
        step(7);
        chk("branch_taken", tk, branch_taken);
        step(1);
        chk("prog_addr", exp, prog_addr);
        chk("exec_nop", tk, exec_nop);
    endtask

    task automatic t_branch();
        logic [7:0] opc [5] = '{OPC_BRANCH_IF_NEGATIVE, OPC_BRANCH_IF_NO_CARRY, OPC_BRANCH_IF_NOT_NEGATIVE,
            OPC_BRANCH_IF_NO_OVERFLOW, OPC_BRANCH_IF_NOT_ZERO};
        // flag that each branch tests, as a bit of {fn, fo, fz, fc}
        logic [3:0] sel [5] = '{4'h8, 4'h1, 4'h8, 4'h4, 4'h2};
        logic [7:0] off;
        logic [10:0] lo;
        logic tk;
        for (int f = 0; f < 2; f++) begin
            off = f[0] ? 8'h80 : 8'h7f;
            lo = f[0] ? 11'h400 : 11'h3ff;
            for (int i = 0; i < 5; i++) begin
                tk = (i == 0) ? f[0] : !f[0];
                @(posedge clk);
                // only the tested flag equals f, so a wrongly wired flag shows
                {fn, fo, fz, fc} <= {4{!f[0]}} ^ sel[i];
                run_br({opc[i], off}, tk, tk ? 21'd2 + {{12{off[7]}}, off, 1'b0} : 21'd4);
            end
            run_br({OPC_BRANCH_ALWAYS, lo}, 1'b1, 21'd2 + {{9{lo[10]}}, lo, 1'b0});
        end
    endtask

    task automatic t_set(logic a, logic x, logic [7:0] f, logic [11:0] ea, logic ix);
        @(posedge clk);
        bank_select_reg <= 4'h3;
        ext_en <= x;
        index_base <= 12'h200;
        m.dmem[ea] = 8'h0a;
        boot({OPC_SET_REGISTER_BIT, 3'd5, a, f}, NOP_WORD, NOP_WORD);
        @(posedge clk);
        clk_en <= 1'b0;
        step(3);
        chk("phase", PH_Q2, phase);
        @(posedge clk);
        clk_en <= 1'b1;
        step(4);
        chk("dm_rd", 1, dm_rd);
        chk("dm_addr", ea, dm_addr);
        chk("indexed_mode", ix, indexed_mode);
        step(3);
        chk("written byte", 8'h2a, m.dmem[ea]);
        chk("exec_nop", 0, exec_nop);
    endtask

    task automatic t_skip();
        logic hit;
        for (int k = 0; k < 8; k++) begin
            hit = (k[0] == k[1]);
            @(posedge clk);
            bank_select_reg <= 4'h1;
            m.dmem[12'h140] = k[0] ? 8'h04 : 8'hfb;
            boot({k[1] ? OPC_TEST_BIT_SKIP_SET : OPC_TEST_BIT_SKIP_CLEAR, 3'd2, 1'b1, 8'h40},
                k[2] ? 16'hee00 : NOP_WORD, 16'hf000);
            step(7);
            chk("skip_next", hit, skip_next);
            step(1);
            chk("exec_nop", hit, exec_nop);
            step(2);
            chk("unsupported", k[2] & !hit, unsupported);
            step(4);
            chk("unsupported", 0, unsupported);
            chk("prog_addr", 6, prog_addr);
        end
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        #20000;
        n_fail++;
        wrap_up();
    end

    initial begin
        clk_en = 1'b1;
        arst_n = 1'b0;
        ext_en = 1'b0;
        index_base = '0;
        bank_select_reg = '0;
        {fn, fo, fz, fc} = '0;
        repeat (6) @(posedge clk);
        t_branch();
        t_set(1'b1, 1'b0, 8'h34, 12'h334, 1'b0);
        t_set(1'b0, 1'b0, 8'h80, 12'hf80, 1'b0);
        t_set(1'b0, 1'b0, 8'h20, 12'h020, 1'b0);
        t_set(1'b0, 1'b1, 8'h10, 12'h210, 1'b1);
        t_set(1'b0, 1'b1, 8'h60, 12'hf60, 1'b0);
        t_skip();
        wrap_up();
    end
endmodule // branch_bitset_skip_exec_bench

// >>> tb/exec_checker.sv
`timescale 1ns/10ps
module exec_checker
    import exec_pkg::*;
#(
    parameter int PC_W = PC_W_DEFAULT
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [PC_W-1:0] prog_addr,
    input wire logic dm_rd,
    input wire logic dm_wr,
    input wire logic [7:0] dm_wdata,
    input wire logic [7:0] dm_rdata,
    input wire logic [1:0] phase,
    input wire logic exec_nop,
    input wire logic branch_taken,
    input wire logic skip_next
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_PHASE_WALK: assert property (clk_en && phase == PH_Q1 |=> phase == PH_Q2)
        else $error("phase did not advance");
    AST_PC_EVEN: assert property (prog_addr[0] == 1'b0)
        else $error("odd program address");
    AST_READ_IN_Q2: assert property (dm_rd |-> phase == PH_Q2 && !dm_wr)
        else $error("data read outside second phase");
    AST_WRITE_AFTER_READ: assert property (dm_wr |-> phase == PH_Q4 && $past(dm_rd, 2))
        else $error("data write without read two cycles before");
    AST_ONE_BIT_SET: assert property (dm_wr |-> (dm_wdata & $past(dm_rdata)) == $past(dm_rdata) && $countones(dm_wdata ^ $past(dm_rdata)) <= 1)
        else $error("write back is not the read byte with one bit set");
    AST_TAKEN_FLUSH: assert property (branch_taken |=> exec_nop [*4])
        else $error("taken branch not followed by a nop cycle");
    AST_SKIP_FLUSH: assert property (skip_next |=> exec_nop [*4])
        else $error("skip not followed by a nop cycle");
    AST_PC_STEP: assert property (clk_en && phase == PH_Q4 && !branch_taken |=> prog_addr == $past(prog_addr) + PC_W'(2))
        else $error("program address did not step by two");
endmodule // exec_checker

bind branch_bitset_skip_exec exec_checker #(.PC_W(PC_W)) chk_i (
    .clk(clk), .arst_n(arst_n), .clk_en(clk_en), .prog_addr(prog_addr), .dm_rd(dm_rd), .dm_wr(dm_wr),
    .dm_wdata(dm_wdata), .dm_rdata(dm_rdata), .phase(phase), .exec_nop(exec_nop),
    .branch_taken(branch_taken), .skip_next(skip_next)
);

// >>> tb/prog_data_model.sv
`timescale 1ns/10ps
module prog_data_model
    import exec_pkg::*;
#(
    parameter int PC_W = PC_W_DEFAULT
) (
    input wire logic clk,
    input wire logic [PC_W-1:0] prog_addr,
    output logic [15:0] prog_rdata,
    input wire logic [DADDR_W-1:0] dm_addr,
    input wire logic dm_rd,
    input wire logic dm_wr,
    input wire logic [7:0] dm_wdata,
    output logic [7:0] dm_rdata
);
    logic [15:0] pmem [16];
    logic [7:0] dmem [4096];
    // small store: far targets read as nop
    assign prog_rdata = (prog_addr[PC_W-1:5] == '0) ? pmem[prog_addr[4:1]] : NOP_WORD;
    // read data only good the cycle after the strobe; toggles otherwise so stale use shows
    always @(posedge clk) begin
        dm_rdata <= dm_rd ? dmem[dm_addr] : ~dm_rdata;
        if (dm_wr) begin
            dmem[dm_addr] <= dm_wdata;
        end
    end
endmodule // prog_data_model
